/* hdl/flash_host.sv */
// host controller driving a parallel flash through its bus pins
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module flash_host #(
  parameter int ADDR_W = 18  // device word address width
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // apb slave
  input  wire flash_host_pkg::apb_req_t apb_i,
  output logic [31:0]                  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // flash control pins
  output flash_host_pkg::flash_ctl_t   ctl_o,
  output logic [ADDR_W-1:0]            addr_bus_o,
  // flash data pins, three signals each
  input  wire logic [15:0]             data_i,
  output logic [15:0]                  data_o,
  output logic [15:0]                  data_oe_o,
  // flash busy line
  input  wire logic                    ready_busy_n_i
);
  // cycle phases, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_READ  = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_RESET = 5'b10000
  } phase_t;

  // whole module state
  typedef struct packed {
    phase_t                  phase;
    logic [7:0]              cnt;
    logic [31:0]             ctrl;
    logic [ADDR_W:0]         addr;    // bit 0 is lsb byte address in byte mode only; word mode puts bits ADDR_W-1:0 on the address pins
    logic [15:0]             wdata;
    logic [15:0]             rdata;
    logic                    busy;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    flash_host_pkg::flash_ctl_t ctl;
    logic [ADDR_W-1:0]       abus;
    logic [15:0]             dout;
    logic [15:0]             doe;
  } state_t;

  state_t s_reg;  // registered state
  state_t s_next; // next state

  // idle pin levels: standby, outputs of device floated
  function automatic flash_host_pkg::flash_ctl_t idle_pins(
    input logic word, input logic unpr);
    flash_host_pkg::flash_ctl_t c;
    c.chip_sel_n          = 1'b1;
    c.out_gate_n          = 1'b1;
    c.write_strobe_n      = 1'b1;
    c.hw_reset_n          = 1'b1;
    c.elevated_id_voltage = unpr;
    c.word_mode           = word;
    return c;
  endfunction : idle_pins

  // byte lsb of the address on the top data pin, other data bits zero
  function automatic logic [15:0] lsb_drive(input logic [ADDR_W:0] a);
    return {a[0], 15'h0000};
  endfunction : lsb_drive

  // next-state logic
  always_comb begin
    logic word;
    logic unpr;
    logic sel;
    word   = s_reg.ctrl[flash_host_pkg::CTRL_WORD_BIT];
    unpr   = s_reg.ctrl[flash_host_pkg::CTRL_UNPR_BIT];
    sel    = 1'b0;
    s_next = s_reg;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    // apb access phase, answered in one cycle
    if (apb_i.psel && apb_i.penable && !s_reg.pready) begin
      sel = 1'b1;
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      if (apb_i.pwrite) begin
        case (apb_i.paddr)
          flash_host_pkg::CTRL_OFF: begin
            if (s_reg.busy) begin
              s_next.pslverr = 1'b1; // refused while busy
            end else begin
              s_next.ctrl = apb_i.pwdata;
            end
          end
          flash_host_pkg::ADDR_OFF: begin
            s_next.addr = apb_i.pwdata[ADDR_W:0];
          end
          flash_host_pkg::WDATA_OFF: begin
            s_next.wdata = apb_i.pwdata[15:0];
          end
          flash_host_pkg::RDATA_OFF,
          flash_host_pkg::STATUS_OFF: begin
            s_next.pslverr = 1'b0; // read only, write ignored
          end
          default: begin
            s_next.pslverr = 1'b1;
          end
        endcase
      end else begin
        case (apb_i.paddr)
          flash_host_pkg::CTRL_OFF:   s_next.prdata = s_reg.ctrl;
          flash_host_pkg::ADDR_OFF:
            s_next.prdata = 32'(s_reg.addr);
          flash_host_pkg::WDATA_OFF:  s_next.prdata = {16'h0000, s_reg.wdata};
          flash_host_pkg::RDATA_OFF:  s_next.prdata = {16'h0000, s_reg.rdata};
          flash_host_pkg::STATUS_OFF:
            s_next.prdata = {30'h0000_0000, ready_busy_n_i, s_reg.busy};
          default: s_next.pslverr = 1'b1;
        endcase
      end
    end
    // start a cycle when go was just written
    if (s_reg.phase == ST_IDLE && s_reg.ctrl[flash_host_pkg::CTRL_GO_BIT]
        && !sel) begin
      s_next.ctrl[flash_host_pkg::CTRL_GO_BIT] = 1'b0;
      s_next.busy = 1'b1;
      // width and unprotect pins follow the ctrl word of this cycle
      s_next.ctl  = idle_pins(word, unpr);
      s_next.abus = s_reg.addr[ADDR_W:1];
      if (word) begin
        s_next.abus = s_reg.addr[ADDR_W-1:0];
      end
      if (s_reg.ctrl[flash_host_pkg::CTRL_RST_BIT]) begin
        s_next.phase = ST_RESET;
        s_next.cnt   = flash_host_pkg::RESET_CNT;
        s_next.ctl.hw_reset_n = 1'b0;
        s_next.doe   = 16'h0000;
      end else if (s_reg.ctrl[flash_host_pkg::CTRL_WR_BIT]) begin
        s_next.phase = ST_WRITE;
        s_next.cnt   = flash_host_pkg::STROBE_CNT;
        s_next.ctl.out_gate_n     = 1'b1;
        s_next.ctl.chip_sel_n     = 1'b0;
        s_next.ctl.write_strobe_n = 1'b0;
        if (word) begin
          s_next.dout = s_reg.wdata;
          s_next.doe  = 16'hFFFF;
        end else begin
          s_next.dout = lsb_drive(s_reg.addr) | {8'h00, s_reg.wdata[7:0]};
          s_next.doe  = 16'h80FF;
        end
      end else begin
        s_next.phase = ST_READ;
        s_next.cnt   = flash_host_pkg::ACCESS_CNT;
        s_next.ctl.chip_sel_n     = 1'b0;
        s_next.ctl.out_gate_n     = 1'b0;
        s_next.ctl.write_strobe_n = 1'b1;
        s_next.dout = lsb_drive(s_reg.addr);
        s_next.doe  = word ? 16'h0000 : 16'h8000;
      end
    end
    // cycle sequencing
    case (s_reg.phase)
      ST_IDLE: begin
        // standby only when no cycle starts on this edge
        if (s_next.phase == ST_IDLE) begin
          s_next.ctl = idle_pins(word, unpr);
        end
      end
      ST_READ: begin
        if (s_reg.cnt == 8'h01) begin
          // low lane only in byte mode, ids too
          s_next.rdata = word ? data_i : {8'h00, data_i[7:0]};
          s_next.ctl   = idle_pins(word, unpr);
          s_next.doe   = 16'h0000;
          s_next.phase = ST_HOLD;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      ST_WRITE: begin
        if (s_reg.cnt == 8'h01) begin
          // strobe and select rise on the same edge, data held one more cycle
          s_next.ctl.write_strobe_n = 1'b1;
          s_next.ctl.chip_sel_n     = 1'b1;
          s_next.phase = ST_HOLD;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      ST_HOLD: begin
        s_next.doe   = 16'h0000;
        s_next.busy  = 1'b0;
        s_next.phase = ST_IDLE;
      end
      ST_RESET: begin
        if (s_reg.cnt == 8'h01) begin
          s_next.ctl.hw_reset_n = 1'b1;
          s_next.phase = ST_HOLD;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      default: begin
        s_next.phase = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg       <= '0;
      s_reg.phase <= ST_IDLE;
      s_reg.ctrl  <= flash_host_pkg::CTRL_RST_VAL;
      s_reg.ctl   <= 6'b111101;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign prdata_o   = s_reg.prdata;
  assign pready_o   = s_reg.pready;
  assign pslverr_o  = s_reg.pslverr;
  assign ctl_o      = s_reg.ctl;
  assign addr_bus_o = s_reg.abus;
  assign data_o     = s_reg.dout;
  assign data_oe_o  = s_reg.doe;
endmodule : flash_host

/* hdl/flash_host_pkg.sv */
// package: register map, pin carriers and timing constants
package flash_host_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] ADDR_OFF   = 8'h04;
  localparam logic [7:0] WDATA_OFF  = 8'h08;
  localparam logic [7:0] RDATA_OFF  = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  // control register fields
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_WR_BIT    = 1;
  localparam int CTRL_WORD_BIT  = 2;
  localparam int CTRL_RST_BIT   = 3;
  localparam int CTRL_UNPR_BIT  = 4;
  // values after reset
  localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0004;
  // bus timing in ns at 40 ns clock
  localparam int CLK_NS      = 40;
  localparam int ACCESS_NS   = 120;
  localparam int STROBE_NS   = 120;
  localparam int RESET_NS    = 500;
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC   = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] ACCESS_CNT = 8'(ACCESS_CYC);
  localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
  localparam logic [7:0] RESET_CNT  = 8'(RESET_CYC);
  // apb request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  // flash control pins
  typedef struct packed {
    logic chip_sel_n;
    logic out_gate_n;
    logic write_strobe_n;
    logic hw_reset_n;
    logic elevated_id_voltage;
    logic word_mode;
  } flash_ctl_t;
endpackage : flash_host_pkg

/* dv/flash_host_props.sv */
// checker on the flash host pins and apb answer
`timescale 1ns/1ps
module flash_host_props (
  // clock, reset, bus
  input wire logic                       clk_i,
  input wire logic                       rst_n_i,
  input wire flash_host_pkg::apb_req_t   apb_i,
  input wire logic                       pready_o,
  // flash pins
  input wire flash_host_pkg::flash_ctl_t ctl_o,
  input wire logic [15:0]                data_o,
  input wire logic [15:0]                data_oe_o
);
  flash_host_pkg::flash_ctl_t c;  // short alias
  assign c = ctl_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_we_high: assert property (!c.chip_sel_n && !c.out_gate_n |->
    c.write_strobe_n) else $error("strobe low in read");
  a_write_gate_high: assert property (!c.write_strobe_n |->
    !c.chip_sel_n && c.out_gate_n) else $error("bad write levels");
  a_read_no_drive: assert property (!c.out_gate_n |->
    data_oe_o[14:0] == 15'h0000) else $error("host drives in read");
  a_byte_high_lane: assert property (!c.word_mode |->
    data_oe_o[14:8] == 7'h00) else $error("high lane driven");
  a_byte_lsb_out: assert property (!c.word_mode && !c.chip_sel_n |->
    data_oe_o[15]) else $error("lsb address not driven");
  a_reset_quiet: assert property (!c.hw_reset_n |-> c.chip_sel_n &&
    c.write_strobe_n && data_oe_o == 16'h0000) else $error("busy in reset");
  a_strobe_len: assert property ($fell(c.write_strobe_n) |->
    !c.write_strobe_n[*3] ##1 c.write_strobe_n) else $error("strobe length");
  a_read_len: assert property ($fell(c.out_gate_n) |->
    !c.out_gate_n[*3] ##1 c.out_gate_n) else $error("gate length");
  a_data_hold: assert property ($rose(c.write_strobe_n) |->
    $stable(data_o) && data_oe_o != 16'h0000) else $error("data not held");
  a_apb_answer: assert property (apb_i.psel && apb_i.penable && !pready_o
    |=> pready_o ##1 !pready_o) else $error("apb answer late");
  cover property ($rose(c.write_strobe_n));
  cover property ($rose(c.out_gate_n));
  cover property ($rose(c.hw_reset_n));
endmodule : flash_host_props
bind flash_host flash_host_props i_flash_host_props (.clk_i, .rst_n_i,
  .apb_i, .pready_o, .ctl_o, .data_o, .data_oe_o);

/* dv/flash_model.sv */
// behavioural parallel flash seen from the host pins
`timescale 1ns/1ps
module flash_model #(
  parameter logic [7:0] ID_CMD  = 8'h5A,  // arbitrary value
  parameter logic [7:0] ID_CODE = 8'h3C,  // arbitrary value
  parameter logic [7:0] ER_CMD  = 8'h96   // arbitrary value
) (
  // host pins
  input wire flash_host_pkg::flash_ctl_t ctl_i,
  input wire logic [17:0]                addr_i,
  input wire logic [15:0]                dq_i,
  // device drive
  output logic [15:0]                    dq_o,
  output logic [15:0]                    dq_oe_o,
  output logic                           rb_n_o
);
  logic [15:0] mem [16];  // small array slice
  logic        id_mode = 1'b0; // identification reads, off at power-up
  logic        strb;      // earlier rise of strobe or select
  logic [3:0]  a;         // word index
  assign a = addr_i[3:0];
  assign strb = ctl_i.write_strobe_n | ctl_i.chip_sel_n;
  assign rb_n_o = 1'b1;
  // drive only in a read; standby, disable and reset float
  assign dq_oe_o = (!ctl_i.chip_sel_n && !ctl_i.out_gate_n &&
    ctl_i.hw_reset_n) ? (ctl_i.word_mode ? 16'hFFFF : 16'h00FF) :
    16'h0000;
  // byte lane picked by the top pin in byte mode
  assign dq_o = id_mode ? {8'h00, ID_CODE} : ctl_i.word_mode ? mem[a] :
    {8'h00, dq_i[15] ? mem[a][15:8] : mem[a][7:0]};
  // command latches, not readable, fed at end of write; reset pin clears
  always @(posedge strb or negedge ctl_i.hw_reset_n) begin
    if (ctl_i.hw_reset_n !== 1'b1) begin
      id_mode = 1'b0;
    end else if (strb && ctl_i.out_gate_n) begin
      if (dq_i[7:0] == ID_CMD) id_mode = 1'b1;
      else if (dq_i[7:0] == ER_CMD) begin
        // sector erase: upper word index bits pick the sector
        for (int i = 0; i < 16; i++) begin
          if (i[3:2] == a[3:2]) mem[i] = 16'hFFFF;
        end
      end
      else if (ctl_i.word_mode) mem[a] = dq_i;
      else if (dq_i[15]) mem[a][15:8] = dq_i[7:0];
      else mem[a][7:0] = dq_i[7:0];
    end
  end
endmodule : flash_model

/* dv/tb.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] IDC = 8'h5A;  // arbitrary value
  localparam logic [7:0] IDV = 8'h3C;  // arbitrary value
  localparam logic [7:0] ERC = 8'h96;  // arbitrary value
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  flash_host_pkg::apb_req_t   apb_i = '0;
  flash_host_pkg::flash_ctl_t ctl_o;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, err, ready_busy_n_i;
  logic [17:0] addr_bus_o;
  logic [15:0] data_i, data_o, data_oe_o, dev_d, dev_oe;
  logic [15:0] flt = 16'h5555;  // released wire pattern
  int error_cnt = 0;
  int check_count = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) flt <= ~flt;
  // wire level from both parties' enables
  assign data_i = (data_oe_o & data_o) | (~data_oe_o & dev_oe & dev_d) |
    (~data_oe_o & ~dev_oe & flt);
  flash_host i_flash_host (.clk_i, .rst_n_i, .apb_i, .prdata_o, .pready_o,
    .pslverr_o, .ctl_o, .addr_bus_o, .data_i, .data_o, .data_oe_o,
    .ready_busy_n_i);
  flash_model #(.ID_CMD(IDC), .ID_CODE(IDV), .ER_CMD(ERC))
    i_flash_model (.ctl_i(ctl_o),
    .addr_i(addr_bus_o), .dq_i(data_i), .dq_o(dev_d), .dq_oe_o(dev_oe),
    .rb_n_o(ready_busy_n_i));
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    @(posedge clk_i);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      got = (pready_o === 1'b1);
    end
    if (!got) begin
      error_cnt++;
      conclude();
    end else begin
      // answer taken and request released at the pready edge
      rd  = prdata_o;
      err = pslverr_o;
      apb_i <= '0;
    end
  endtask : apb
  task automatic idle;
    repeat (50) begin
      apb(1'b0, flash_host_pkg::STATUS_OFF, 32'h0);
      if (rd[0] === 1'b0) return;
    end
    error_cnt++;
    conclude();
  endtask : idle
  // one flash cycle, then fetch the result
  task automatic op(input logic [31:0] a, d, c);
    apb(1'b1, flash_host_pkg::ADDR_OFF, a);
    apb(1'b1, flash_host_pkg::WDATA_OFF, d);
    apb(1'b1, flash_host_pkg::CTRL_OFF, c);
    idle();
    apb(1'b0, flash_host_pkg::RDATA_OFF, 32'h0);
  endtask : op
  task automatic t_regs;
    chk("ctl standby", 32'h3D, ctl_o);
    apb(1'b0, flash_host_pkg::CTRL_OFF, 32'h0);
    chk("ctrl reset", flash_host_pkg::CTRL_RST_VAL, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, err);
    apb(1'b0, flash_host_pkg::STATUS_OFF, 32'h0);
    chk("status idle", 32'h2, rd);
    apb(1'b1, flash_host_pkg::CTRL_OFF, 32'h14);
    @(posedge clk_i);
    chk("unprotect pin", 32'h1, ctl_o.elevated_id_voltage);
    apb(1'b1, flash_host_pkg::CTRL_OFF, 32'h4);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_word;
    op(32'h5, 32'h1234, 32'h7);
    op(32'h6, 32'hBEEF, 32'h7);
    op(32'h5, 32'h0, 32'h5);
    chk("word read", 32'h1234, rd[15:0]);
    $display("t_word done");
  endtask : t_word
  task automatic t_byte;
    op(32'hB, 32'hAB, 32'h3);
    op(32'hA, 32'hCD, 32'h3);
    op(32'hB, 32'h0, 32'h1);
    chk("byte read", 32'hAB, rd[7:0]);
    op(32'h5, 32'h0, 32'h5);
    chk("byte merge", 32'hABCD, rd[15:0]);
    $display("t_byte done");
  endtask : t_byte
  task automatic t_id;
    op(32'h0, IDC, 32'h7);
    op(32'h5, 32'h0, 32'h5);
    chk("id code", IDV, rd[7:0]);
    op(32'h0, 32'h0, 32'h9);
    op(32'h5, 32'h0, 32'h5);
    chk("array after reset", 32'hABCD, rd[15:0]);
    $display("t_id done");
  endtask : t_id
  task automatic t_erase;
    op(32'hC, ERC, 32'h7);
    op(32'h5, 32'h0, 32'h5);
    chk("other sector kept", 32'hABCD, rd[15:0]);
    op(32'h4, ERC, 32'h7);
    op(32'h5, 32'h0, 32'h5);
    chk("sector erased", 32'hFFFF, rd[15:0]);
    $display("t_erase done");
  endtask : t_erase
  task automatic t_busy;
    apb(1'b1, flash_host_pkg::CTRL_OFF, 32'h5);
    apb(1'b1, flash_host_pkg::CTRL_OFF, 32'h5);
    chk("busy refuse", 32'h1, err);
    idle();
    $display("t_busy done");
  endtask : t_busy
  initial begin
    repeat (12) @(posedge clk_i);
    chk("ctl in reset", 32'h3D, ctl_o);
    rst_n_i <= 1'b1;
    t_regs();
    t_word();
    t_byte();
    t_id();
    t_erase();
    t_busy();
    conclude();
  end
endmodule : tb
